// File: testbench.sv
// Purpose: self-checking bench of the decision core
// Assumes: centre probe carries the direction, outer probes stay zero
// Notes: each quarter period is held two cycles
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import wsd_pkg::*;
  logic sys_clk, reset, underVoltage, deepDrop, calibrated, uvArmed;
  wsd_in_s sampleIn;
  wsd_out_s outEvent;
  logic [7:0] pulseCount;
  wsd_dir_e lastDir, fwdDir;
  int n_fail, compares;
  wsd_core DUT (.sys_clk(sys_clk), .reset(reset), .sampleIn(sampleIn),
    .underVoltage(underVoltage), .deepDrop(deepDrop), .outEvent(outEvent),
    .calibrated(calibrated), .uvArmed(uvArmed));
  wsd_tcu_model tcu (.sys_clk(sys_clk), .reset(reset), .outEvent(outEvent),
    .pulseCount(pulseCount), .lastDir(lastDir));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // hold one sample for n cycles, driven just after the edge
  task automatic step(logic signed [11:0] spd, logic signed [11:0] dirv, int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 sampleIn = '{1'b1, spd, 12'sh000, 12'sh000, dirv};
    end
  endtask
  task automatic period(logic signed [11:0] a, logic signed [11:0] d);
    step(12'sh000, d, 2);
    step(a, 12'sh000, 2);
    step(12'sh000, -d, 2);
    // direction leads into the next rising zero, where the core samples it
    step(-a, 12'sh000, 1);
    step(-a, d, 1);
  endtask
  task automatic t_start;
    underVoltage = 1'b1;
    step(12'sh000, 12'sh000, 3);
    check("highCurUnarmed", 8'h00, {7'h00, outEvent.highCur});
    underVoltage = 1'b0;
    step(12'sh040, 12'sh000, 3);
    check("pulsesAtLimit", 8'h00, pulseCount);
    step(12'sh050, 12'sh000, 3);
    check("firstPulse", 8'h01, pulseCount);
    check("firstDir", 8'(WSD_DIR_NONE), 8'(lastDir));
    check("armed", 8'h01, {7'h00, uvArmed});
    repeat (2) begin
      step(12'sh048, 12'sh000, 2);
      step(12'sh050, 12'sh000, 2);
    end
    check("wiggle", 8'h01, pulseCount);
  endtask
  task automatic t_uv;
    underVoltage = 1'b1;
    step(12'sh050, 12'sh000, 2);
    check("highCurOn", 8'h01, {7'h00, outEvent.highCur});
    underVoltage = 1'b0;
    step(12'sh050, 12'sh000, 2);
    check("highCurOff", 8'h00, {7'h00, outEvent.highCur});
  endtask
  task automatic t_cal;
    repeat (6) period(12'sh100, 12'sh080);
    check("calibrated", 8'h01, {7'h00, calibrated});
    fwdDir = lastDir;
    check("dirKnown", 8'h01, {7'h00, fwdDir != WSD_DIR_NONE});
    repeat (4) period(12'sh100, -12'sh080);
    check("dirReversed", 8'((fwdDir == WSD_DIR_FWD) ? WSD_DIR_REV : WSD_DIR_FWD), 8'(lastDir));
  endtask
  // small periods after a reversal: one reversed edge is wobble and dropped
  task automatic t_vib;
    logic [7:0] base;
    base = pulseCount;
    repeat (3) period(12'sh030, 12'sh080);
    check("vibDrop", base + 8'h02, pulseCount);
    check("vibDir", 8'(WSD_DIR_FWD), 8'(lastDir));
  endtask
  task automatic t_drop;
    logic [7:0] base;
    deepDrop = 1'b1;
    step(12'sh000, 12'sh000, 1);
    deepDrop = 1'b0;
    step(12'sh000, 12'sh000, 2);
    check("dropCal", 8'h00, {7'h00, calibrated});
    check("dropArm", 8'h00, {7'h00, uvArmed});
    base = pulseCount;
    step(12'sh050, 12'sh000, 3);
    check("restartPulse", base + 8'h01, pulseCount);
    check("restartDir", 8'(WSD_DIR_NONE), 8'(lastDir));
  endtask
  task automatic results;
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // guard against a hung run, far beyond the about 150 cycles needed
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    results();
  end
  initial begin
    reset = 1'b1;
    underVoltage = 1'b0;
    deepDrop = 1'b0;
    sampleIn = '0;
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    t_start();
    t_uv();
    t_cal();
    t_vib();
    t_drop();
    results();
  end
endmodule // testbench
`default_nettype wire

// File: wsd_core.sv
// Purpose: speed / direction decision core with adaptive hysteresis and vibration filter
// Assumes: samples synchronous to sys_clk, qualified by the valid bit
// Notes: supply monitors arrive as digital flags from the analog domain
//   the probe stage is not cleared by a deep drop; it refills in one sample
// Function
// R1: the hysteresis tracks one quarter of the measured signal amplitude.
// R2: the hysteresis never falls below the minimum speed amplitude.
// R3: excursions smaller than the hysteresis never switch the output.
// R4: direction signal is centre probe minus the mean of the outer probes.
// R5: direction is sampled from the direction signal at speed zero crossings.
// R6: the first pulse after power on carries no direction.
// R7: amplitude and direction both classify edges as vibration.
// R8: edges classified as vibration produce no output pulse.
// R9: hysteresis suppression works from power on, direction suppression after calibration.
// R10: undervoltage monitoring arms only at the first switching events.
// R11: an armed undervoltage forces high current until the supply recovers.
// R12: a deep supply drop resets the core and restarts calibration.
// R13: calibrated mode follows a successful offset fix and then uses the hysteresis.
// R14: uncalibrated pulses use a noise threshold starting at twice the minimum amplitude.
// R15: the hysteresis is a register fed by peaks and compared every sample.
`timescale 1ns/10ps
`default_nettype none
module wsd_core
  import wsd_pkg::*;
#(
  parameter logic [11:0] SPEED_LIMIT = wsd_pkg::SPEED_LIMIT_RST
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire wsd_pkg::wsd_in_s sampleIn,
  input wire logic underVoltage,
  input wire logic deepDrop,
  output wsd_pkg::wsd_out_s outEvent,
  output logic calibrated,
  output logic uvArmed
);
  import wsd_pkg::*;

  localparam int W = SMP_W;

  typedef struct packed {
    wsd_mode_e mode;
    logic [W-1:0] hysteresis;           // adaptive threshold
    logic [W-1:0] noiseDetectThreshold; // uncalibrated threshold
    logic signed [W-1:0] peakHi;
    logic signed [W-1:0] peakLo;
    logic signed [W-1:0] lastSwitch;    // extreme level since the last switching point
    logic state;                        // comparator state, 1 = high
    wsd_dir_e lastDir;
    logic anyPulse;
    logic [2:0] extrema;
    logic [1:0] switches;
    logic uvArm;
    wsd_out_s out;
  } wsd_state_s;

  // restart value of the whole state, shared by reset and deep drop
  localparam wsd_state_s RST_STATE = '{
    mode: WSD_UNCAL,
    hysteresis: W'(SPEED_LIMIT),
    noiseDetectThreshold: W'(SPEED_LIMIT) << NOISE_MULT_SHIFT,
    peakHi: '0,
    peakLo: '0,
    lastSwitch: '0,
    state: 1'b0,
    lastDir: WSD_DIR_NONE,
    anyPulse: 1'b0,
    extrema: 3'h0,
    switches: 2'h0,
    uvArm: 1'b0,
    out: '{pulse: 1'b0, dir: WSD_DIR_NONE, highCur: 1'b0}
  };

  wsd_state_s cur_reg;
  wsd_state_s cur_next;
  logic signed [W:0] dirSignal;

  // R4: direction signal former
  wsd_dir_signal #(.W(W)) u_dir (
    .sys_clk(sys_clk),
    .reset(reset),
    .leftProbeField(sampleIn.leftProbeField),
    .rightProbeField(sampleIn.rightProbeField),
    .centerProbeField(sampleIn.centerProbeField),
    .dirSignal(dirSignal)
  );

  // amplitude and threshold path
  logic [W:0] ampFull;
  logic [W-1:0] amp;
  logic [W-1:0] hysCand;
  logic [W-1:0] noiseMin;
  logic [W-1:0] hysNext;
  logic [W-1:0] noiseNext;
  logic [W-1:0] thresh;
  logic signed [W:0] threshExt;
  logic signed [W:0] excursion;
  logic crossUp;
  logic crossDn;

  // direction, vibration and supply path
  wsd_dir_e edgeDir;
  logic dirReversal;
  logic ampSmall;
  logic vibration;
  logic dirFilterOn;
  logic forceHigh;

  // decision and tracking logic
  always_comb begin
    cur_next = cur_reg;
    cur_next.out.pulse = 1'b0;
    ampFull = (W+1)'(cur_reg.peakHi) - (W+1)'(cur_reg.peakLo);
    amp = ampFull[W:1]; // half peak to peak
    noiseMin = W'(SPEED_LIMIT) << NOISE_MULT_SHIFT;
    // R1: quarter of amplitude
    hysCand = amp >> HYS_SHIFT;
    // R2: hysteresis floor
    hysNext = (hysCand < W'(SPEED_LIMIT)) ? W'(SPEED_LIMIT) : hysCand;
    // R14: adapt, never below twice the limit
    noiseNext = (amp < noiseMin) ? noiseMin : amp;

    // measured from the extreme seen since the last switch point
    excursion = (W+1)'(sampleIn.speed) - (W+1)'(cur_reg.lastSwitch);
    // R13: calibrated uses hysteresis; R14: else noise threshold
    thresh = (cur_reg.mode == WSD_CAL) ? cur_reg.hysteresis : cur_reg.noiseDetectThreshold;
    // low bits only; thresholds never reach half scale
    threshExt = $signed({2'b00, thresh[W-2:0]});
    // R3: R15: switch only past the threshold
    crossUp = !cur_reg.state && (excursion > threshExt);
    crossDn = cur_reg.state && (-excursion > threshExt);

    // R5: sign of direction signal at the crossing
    // the probe sample one step before the crossing; zero reads as forward
    edgeDir = dirSignal[W] ? WSD_DIR_REV : WSD_DIR_FWD;
    // R7: reversal against a small amplitude is vibration
    dirReversal = (cur_reg.lastDir != WSD_DIR_NONE) && (edgeDir != cur_reg.lastDir);
    // a real reversal shows full amplitude, air gap wobble does not
    ampSmall = (amp < noiseMin);
    vibration = dirReversal && ampSmall;
    // R9: direction filter waits for calibration
    dirFilterOn = (cur_reg.mode == WSD_CAL);

    // R11: armed before this sample, so arming never mutes its own pulse
    forceHigh = cur_reg.uvArm && underVoltage;

    if (sampleIn.valid) begin
      // peak tracking
      if (sampleIn.speed > cur_reg.peakHi) begin
        cur_next.peakHi = sampleIn.speed;
      end
      if (sampleIn.speed < cur_reg.peakLo) begin
        cur_next.peakLo = sampleIn.speed;
      end
      // follow the signal between switch points
      if (cur_reg.state && sampleIn.speed > cur_reg.lastSwitch) begin
        cur_next.lastSwitch = sampleIn.speed;
      end
      if (!cur_reg.state && sampleIn.speed < cur_reg.lastSwitch) begin
        cur_next.lastSwitch = sampleIn.speed;
      end
      // a falling crossing re-arms the comparator but never pulses
      if (crossUp || crossDn) begin
        cur_next.state = crossUp;
        cur_next.lastSwitch = sampleIn.speed;
        // R15: thresholds follow the half period just ended
        cur_next.hysteresis = hysNext;
        cur_next.noiseDetectThreshold = noiseNext;
        if (cur_reg.extrema != CAL_EXTREMA) begin
          cur_next.extrema = cur_reg.extrema + 3'h1;
        end
        // restart peak window for the next half period
        cur_next.peakHi = sampleIn.speed;
        cur_next.peakLo = sampleIn.speed;
        // R13: offset fix after two extrema on a rising edge
        if (cur_reg.extrema == CAL_EXTREMA && crossUp) begin
          cur_next.mode = WSD_CAL;
        end
        if (crossUp) begin
          // R8: drop vibration edges, by direction only once calibrated
          if (!(dirFilterOn && vibration)) begin
            cur_next.out.pulse = 1'b1;
            // R6: no direction on first pulse
            cur_next.out.dir = cur_reg.anyPulse ? edgeDir : WSD_DIR_NONE;
            // a pulse dropped as vibration does not count as the first
            cur_next.anyPulse = 1'b1;
            if (cur_reg.switches != ARM_EDGES) begin
              cur_next.switches = cur_reg.switches + 2'h1;
            end
            // R10: arm monitor at first switching
            if (cur_reg.switches == ARM_EDGES - 2'h1) begin
              cur_next.uvArm = 1'b1;
            end
          end
          // a dropped edge still sets the reference direction
          cur_next.lastDir = edgeDir;
        end
      end
    end
    // R11: high current while armed undervoltage
    cur_next.out.highCur = forceHigh;
    // the current level carries no pulse while forced high
    if (forceHigh) begin
      cur_next.out.pulse = 1'b0;
    end
  end

  // state register; deep drop acts as core reset
  always_ff @(posedge sys_clk) begin
    // R12: deep drop full restart
    if (reset || deepDrop) begin
      cur_reg <= RST_STATE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // outputs straight from the state flops
  assign outEvent = cur_reg.out;
  // mode bit 0 is the calibrated flag, taken straight from the flop
  assign calibrated = cur_reg.mode[0];
  assign uvArmed = cur_reg.uvArm;
endmodule // wsd_core
`default_nettype wire

// File: wsd_core_assertions.sv
// Purpose: port-level checker of the decision core
// Assumes: bound onto every wsd_core instance
// Notes: deep drop clears state like reset
`timescale 1ns/10ps
`default_nettype none
module wsd_core_checker
  import wsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire wsd_pkg::wsd_in_s sampleIn,
  input wire logic underVoltage,
  input wire logic deepDrop,
  input wire wsd_pkg::wsd_out_s outEvent,
  input wire logic calibrated,
  input wire logic uvArmed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic seenPulse_reg;
  // remembers a pulse since the last restart
  always_ff @(posedge sys_clk) begin
    seenPulse_reg <= (reset || deepDrop) ? 1'b0 : (seenPulse_reg || outEvent.pulse);
  end
  sequence uvHeld;
    uvArmed && underVoltage && !deepDrop;
  endsequence
  sequence firstPulse;
    outEvent.pulse && !seenPulse_reg;
  endsequence
  AST_PULSE_ONE: assert property (outEvent.pulse |=> !outEvent.pulse)
    else $error("pulse longer than one cycle");
  AST_DROP_CLEAR: assert property (deepDrop |=> !calibrated && !uvArmed && !outEvent.pulse)
    else $error("deep drop left state behind");
  AST_HICUR_ON: assert property (uvHeld |=> outEvent.highCur)
    else $error("high current missing");
  AST_HICUR_OFF: assert property (!(uvArmed && underVoltage) |=> !outEvent.highCur)
    else $error("high current without armed undervoltage");
  AST_ARM_AT_PULSE: assert property ($rose(uvArmed) |-> outEvent.pulse)
    else $error("monitor armed without switching");
  AST_PULSE_CAUSE: assert property (outEvent.pulse |-> $past(sampleIn.valid))
    else $error("pulse without a sample");
  AST_DIR_HOLD: assert property (!outEvent.pulse && !$past(deepDrop) |-> $stable(outEvent.dir))
    else $error("direction changed between pulses");
  AST_FIRST_NODIR: assert property (firstPulse |-> outEvent.dir == WSD_DIR_NONE)
    else $error("first pulse carries a direction");
  AST_HICUR_MUTE: assert property (outEvent.highCur && $past(outEvent.highCur) |-> !outEvent.pulse)
    else $error("pulse under high current");
endmodule // wsd_core_checker
bind wsd_core wsd_core_checker chk (.sys_clk(sys_clk), .reset(reset), .sampleIn(sampleIn),
  .underVoltage(underVoltage), .deepDrop(deepDrop), .outEvent(outEvent),
  .calibrated(calibrated), .uvArmed(uvArmed));
`default_nettype wire

// File: wsd_dir_signal.sv
// Purpose: forms the direction signal from the three probe fields
// Assumes: one registered stage of latency
// Notes: centre minus mean of outer probes, one bit wider to avoid overflow
`timescale 1ns/10ps
`default_nettype none
module wsd_dir_signal #(
  parameter int W = 12
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic signed [W-1:0] leftProbeField,
  input wire logic signed [W-1:0] rightProbeField,
  input wire logic signed [W-1:0] centerProbeField,
  output logic signed [W:0] dirSignal
);
  logic signed [W+1:0] outerSum;
  logic signed [W+1:0] diffFull;

  // R4: centre minus outer mean
  always_comb begin
    outerSum = (W+2)'(leftProbeField) + (W+2)'(rightProbeField);
    diffFull = (W+2)'(centerProbeField) - (outerSum >>> 1);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dirSignal <= '0;
    end else begin
      dirSignal <= diffFull[W:0];
    end
  end
endmodule // wsd_dir_signal
`default_nettype wire

// File: wsd_pkg.sv
// Purpose: shared types and constants of the wheel speed / direction decision core
// Assumes: speed and direction signals arrive as signed digitized samples
// Notes: amplitudes are in adc codes; thresholds are half-peak-to-peak amplitudes
package wsd_pkg;
  localparam int SMP_W = 12;                          // sample width
  localparam logic [11:0] SPEED_LIMIT_RST = 12'h020; // minimum speed amplitude
  localparam int HYS_SHIFT = 2;                       // hysteresis = amplitude / 4
  localparam int NOISE_MULT_SHIFT = 1;                // start threshold = 2 x limit
  localparam logic [2:0] CAL_EXTREMA = 3'h2;          // extrema needed for offset fix
  localparam logic [1:0] ARM_EDGES = 2'h1;            // switch events before uv arm

  typedef enum logic [1:0] {
    WSD_UNCAL = 2'b00,
    WSD_CAL = 2'b01
  } wsd_mode_e;

  typedef enum logic [1:0] {
    WSD_DIR_NONE = 2'b00,
    WSD_DIR_FWD = 2'b01,
    WSD_DIR_REV = 2'b10
  } wsd_dir_e;

  // one decided output event
  typedef struct packed {
    logic pulse;     // one-cycle output pulse
    wsd_dir_e dir;   // direction carried by the pulse
    logic highCur;   // forced high current level
  } wsd_out_s;

  // digitized inputs of one sample
  typedef struct packed {
    logic valid;
    logic signed [SMP_W-1:0] speed;
    logic signed [SMP_W-1:0] leftProbeField;
    logic signed [SMP_W-1:0] rightProbeField;
    logic signed [SMP_W-1:0] centerProbeField;
  } wsd_in_s;
endpackage : wsd_pkg

// File: wsd_tcu_model.sv
// Purpose: control unit model that decodes the core's output pulses
// Assumes: one-cycle pulses, direction valid with the pulse
// Notes: pulses under forced high current are not decoded
`timescale 1ns/10ps
`default_nettype none
module wsd_tcu_model
  import wsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire wsd_pkg::wsd_out_s outEvent,
  output logic [7:0] pulseCount,
  output wsd_pkg::wsd_dir_e lastDir
);
  // count pulses and keep the direction each one carried
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pulseCount <= 8'h00;
      lastDir <= WSD_DIR_NONE;
    end else if (outEvent.pulse && !outEvent.highCur) begin
      pulseCount <= pulseCount + 8'h01;
      lastDir <= outEvent.dir;
    end
  end
endmodule // wsd_tcu_model
`default_nettype wire
